//--- design/ssc_pkg.sv
package ssc_pkg;
  // ascii characters
  localparam logic [7:0] C_AT = 8'h40;
  localparam logic [7:0] C_SEMI = 8'h3b;
  localparam logic [7:0] C_F = 8'h46;
  localparam logic [7:0] C_Q = 8'h3f;
  localparam logic [7:0] C_EXCL = 8'h21;
  localparam logic [7:0] C_ZERO = 8'h30;
  localparam logic [7:0] C_DOT = 8'h2e;
  localparam logic [7:0] C_E = 8'h45;
  localparam logic [7:0] C_PLUS = 8'h2b;
  localparam logic [7:0] C_MINUS = 8'h2d;
  localparam logic [7:0] C_A = 8'h41;
  localparam logic [7:0] C_D = 8'h44;
  localparam logic [7:0] C_H = 8'h48;
  localparam logic [7:0] C_N = 8'h4e;
  localparam logic [7:0] C_P = 8'h50;
  localparam logic [7:0] C_R = 8'h52;
  localparam logic [7:0] C_S = 8'h53;
  // ascii words
  localparam logic [15:0] W_ON = 16'h4f4e;
  localparam logic [23:0] W_OFF = 24'h4f4646;
  localparam logic [39:0] W_ABOVE = 40'h41424f5645;
  localparam logic [39:0] W_BELOW = 40'h42454c4f57;
  localparam logic [23:0] W_ACK = 24'h41434b;
  localparam logic [23:0] W_NAK = 24'h4e414b;
  localparam logic [23:0] NAK_UNREC = 24'h313630;
  localparam logic [23:0] NAK_ARG = 24'h313639;
  localparam logic [23:0] NAK_RANGE = 24'h313732;
  localparam logic [23:0] NAK_LOCK = 24'h313830;
  // node addresses as three ascii digits
  localparam logic [23:0] ADDR_MIN = 24'h303031;
  localparam logic [23:0] ADDR_MAX = 24'h323533;
  localparam logic [23:0] ADDR_DEFAULT = 24'h323533;
  localparam logic [23:0] ADDR_ECHO = 24'h323534;
  localparam logic [23:0] ADDR_SILENT = 24'h323535;
  // value key: {exponent + 16, binary mantissa 100..999}
  localparam logic [4:0] EXP_BIAS = 5'h10;
  localparam logic [14:0] SP_DEFAULT = 15'h4064;
  localparam logic [14:0] SH_DEFAULT = 15'h406e;
  localparam logic [4:0] RES_ONE_EXP = 5'h0b;
  localparam logic [4:0] RES_TWO_EXP = 5'h0c;
  localparam logic [2:0] SAFETY_COUNT = 3'h5;
  localparam logic [4:0] TURN_BITS = 5'h0a;
  // avalon map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD_DIV = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_UNIT_LSB = 1;
  localparam int CTRL_BAUD_LSB = 4;
  localparam int BAUD_SEL_W = 3;
  localparam logic [2:0] BAUD_SEL_DEFAULT = 3'h1;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h65ba;
  typedef enum logic [3:0] {
    ST_RX = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_TX = 4'b1000
  } ssc_state_t;
endpackage

//--- design/ssc_top.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ssc_top #(
  parameter int MSG_MAX = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [ssc_pkg::BAUD_SEL_W-1:0] baud_sel,
  // measurement
  input wire logic meas_valid,
  input wire logic [15:0] meas_mant_bcd,
  input wire logic [4:0] meas_exp,
  // relays and display
  input wire logic relays_fitted,
  output logic [2:0] relay_out,
  output logic [1:0] disp_unit
);
  import ssc_pkg::*;

  function automatic logic is_dig(input logic [7:0] c);
    is_dig = (c >= C_ZERO) && (c <= 8'h39);
  endfunction

  function automatic logic [63:0] fmt_key(input logic [14:0] k);
    logic [9:0] m;
    logic [4:0] e;
    logic [3:0] d0, d1, d2;
    m = k[9:0];
    e = k[14:10];
    d0 = 4'((m / 10'd100) % 10'd10);
    d1 = 4'((m / 10'd10) % 10'd10);
    d2 = 4'(m % 10'd10);
    fmt_key = {C_ZERO | {4'h0, d0}, C_DOT, C_ZERO | {4'h0, d1},
               C_ZERO | {4'h0, d2}, C_E, (e < EXP_BIAS) ? C_MINUS : C_PLUS,
               C_ZERO | {3'h0, (e < EXP_BIAS) ? EXP_BIAS - e : e - EXP_BIAS},
               8'h00};
  endfunction

  // auto hysteresis: setpoint plus or minus a tenth
  function automatic logic [14:0] auto_hy(input logic [14:0] k, input logic above);
    logic [10:0] m;
    logic [4:0] e;
    m = {1'b0, k[9:0]};
    e = k[14:10];
    m = above ? m - m / 11'd10 : m + m / 11'd10;
    if (m > 11'd999) begin
      m = m / 11'd10;
      e = e + 5'h01;
    end else if (m < 11'd100) begin
      m = 11'(m * 11'd10);
      e = e - 5'h01;
    end
    auto_hy = {e, m[9:0]};
  endfunction

  ssc_state_t state;
  logic [7:0] mbuf [0:MSG_MAX-1];
  logic [4:0] mlen;
  logic mactive;
  logic [23:0] node_addr;
  logic rsd_on, spd_on, lock;
  logic [2:0] baud_pend;
  logic [15:0] baud_div;
  logic [14:0] sp_key [0:2];
  logic [14:0] hy_key [0:2];
  logic [2:0] sp_above, sp_en;
  wire [2:0] relay_state;
  logic [23:0] rep_addr, rep_word;
  logic [63:0] rep_pay;
  logic [3:0] rep_plen;
  logic [19:0] wait_cnt;
  logic [4:0] tx_idx;

  //////////////////////////////////////////////////////////////////////
  // message decode
  wire [7:0] rx_up = (rx_data >= 8'h61 && rx_data <= 8'h7a) ? rx_data - 8'h20 : rx_data;
  wire msg_end = rx_up == C_F && mlen >= 5'd2 && mbuf[mlen - 5'd1] == C_F
                 && mbuf[mlen - 5'd2] == C_SEMI;
  wire [23:0] msg_addr = {mbuf[0], mbuf[1], mbuf[2]};
  wire addr_silent = msg_addr == ADDR_SILENT;
  wire addr_any = msg_addr == node_addr || msg_addr == ADDR_ECHO || addr_silent;
  wire is_ad = mbuf[3] == C_A && mbuf[4] == C_D;
  wire [4:0] op_pos = is_ad ? 5'd5 : 5'd6;
  wire [4:0] tpos = mlen - 5'd3;
  wire msg_short = mlen < 5'd6 || tpos <= op_pos;
  wire [7:0] op_ch = mbuf[op_pos];
  wire [4:0] arg_len = tpos - op_pos - 5'd1;
  wire [63:0] arg_w;
  for (genvar k = 0; k < 8; k++) begin : g_arg
    assign arg_w[63-8*k -: 8] = mbuf[op_pos + 5'(k + 1)];
  end
  wire ch_ok = mbuf[5] >= 8'h31 && mbuf[5] <= 8'h33;
  wire [1:0] ch = mbuf[5][1:0] - 2'h1;
  wire is_s = mbuf[3] == C_S;
  wire is_sp = is_s && mbuf[4] == C_P && ch_ok;
  wire is_sd = is_s && mbuf[4] == C_D && ch_ok;
  wire is_sh = is_s && mbuf[4] == C_H && ch_ok;
  wire is_en = mbuf[3] == C_E && mbuf[4] == C_N && ch_ok;
  wire is_spd = is_s && mbuf[4] == C_P && mbuf[5] == C_D;
  wire is_rsd = mbuf[3] == C_R && mbuf[4] == C_S && mbuf[5] == C_D;
  wire is_pr = mbuf[3] == C_P && mbuf[4] == C_R && (mbuf[5] == 8'h31 || mbuf[5] == 8'h34);
  wire recog = is_ad | is_rsd | is_spd | is_sp | is_sd | is_sh | is_en | is_pr;
  wire is_query = msg_short ? 1'b0 : op_ch == C_Q && tpos == op_pos + 5'd1;
  wire is_set = !msg_short && op_ch == C_EXCL;
  wire arg_on = arg_len == 5'd2 && arg_w[63:48] == W_ON;
  wire arg_off = arg_len == 5'd3 && arg_w[63:40] == W_OFF;
  wire arg_above = arg_len == 5'd5 && arg_w[63:24] == W_ABOVE;
  wire arg_below = arg_len == 5'd5 && arg_w[63:24] == W_BELOW;
  wire arg_addr = arg_len == 5'd3 && is_dig(arg_w[63:56]) && is_dig(arg_w[55:48])
                  && is_dig(arg_w[47:40]);
  wire addr_in_range = arg_w[63:40] >= ADDR_MIN && arg_w[63:40] <= ADDR_MAX;
  wire arg_val = arg_len == 5'd7 && is_dig(arg_w[63:56]) && arg_w[55:48] == C_DOT
                 && is_dig(arg_w[47:40]) && is_dig(arg_w[39:32]) && arg_w[31:24] == C_E
                 && (arg_w[23:16] == C_PLUS || arg_w[23:16] == C_MINUS)
                 && is_dig(arg_w[15:8]) && arg_w[59:56] != 4'h0;
  wire [9:0] val_m = 10'(arg_w[59:56] * 7'd100 + arg_w[43:40] * 4'd10 + arg_w[35:32]);
  wire [4:0] val_e = arg_w[23:16] == C_MINUS ? EXP_BIAS - {1'b0, arg_w[11:8]}
                                             : EXP_BIAS + {1'b0, arg_w[11:8]};
  wire [14:0] val_key = {val_e, val_m};

  //////////////////////////////////////////////////////////////////////
  // pressure view
  wire [9:0] meas_m = 10'(meas_mant_bcd[15:12] * 7'd100 + meas_mant_bcd[11:8] * 4'd10
                      + meas_mant_bcd[7:4]);
  wire [14:0] meas_key = {meas_exp + EXP_BIAS, meas_m};
  logic [15:0] pr_bcd;
  logic [4:0] pr_e;
  wire [15:0] pr_res = pr_e <= RES_ONE_EXP ? {pr_bcd[15:12], 12'h000} :
                       pr_e == RES_TWO_EXP ? {pr_bcd[15:8], 8'h00} : pr_bcd;
  wire [7:0] pr_sign = pr_e < EXP_BIAS ? C_MINUS : C_PLUS;
  wire [7:0] pr_edig = C_ZERO | {3'h0, pr_e < EXP_BIAS ? EXP_BIAS - pr_e : pr_e - EXP_BIAS};
  wire [63:0] pr_long = {C_ZERO | {4'h0, pr_res[15:12]}, C_DOT, C_ZERO | {4'h0, pr_res[11:8]},
                         C_ZERO | {4'h0, pr_res[7:4]}, C_ZERO | {4'h0, pr_res[3:0]},
                         C_E, pr_sign, pr_edig};
  wire [63:0] pr_short = {pr_long[63:32], pr_long[23:0], 8'h00};

  //////////////////////////////////////////////////////////////////////
  // command execution decision
  logic d_nak;
  logic [23:0] d_code;
  logic [63:0] d_pay;
  logic [3:0] d_plen;
  logic d_write;
  always_comb begin
    d_nak = 1'b1;
    d_code = NAK_UNREC;
    d_pay = {NAK_UNREC, 40'h0};
    d_plen = 4'h3;
    d_write = 1'b0;
    if (recog && is_query) begin
      d_nak = 1'b0;
      d_plen = 4'h7;
      d_pay = 64'h0;
      if (is_ad) begin
        d_pay = {node_addr, 40'h0};
        d_plen = 4'h3;
      end else if (is_rsd || is_spd || is_en) begin
        d_pay = (is_rsd ? rsd_on : is_spd ? spd_on : sp_en[ch]) ? {W_ON, 48'h0}
                                                                : {W_OFF, 40'h0};
        d_plen = (is_rsd ? rsd_on : is_spd ? spd_on : sp_en[ch]) ? 4'h2 : 4'h3;
      end else if (is_sd) begin
        d_pay = {sp_above[ch] ? W_ABOVE : W_BELOW, 24'h0};
        d_plen = 4'h5;
      end else if (is_sp || is_sh) begin
        d_pay = fmt_key(is_sp ? sp_key[ch] : hy_key[ch]);
      end else begin
        d_pay = mbuf[5] == 8'h34 ? pr_long : pr_short;
        d_plen = mbuf[5] == 8'h34 ? 4'h8 : 4'h7;
      end
    end else if (recog && is_set && !is_pr) begin
      if (lock) begin
        d_code = NAK_LOCK;
      end else if (is_ad ? !arg_addr : (is_rsd || is_spd || is_en) ? !(arg_on || arg_off) :
                   is_sd ? !(arg_above || arg_below) : !arg_val) begin
        d_code = NAK_ARG;
      end else if (is_ad && !addr_in_range) begin
        d_code = NAK_RANGE;
      end else begin
        d_nak = 1'b0;
        d_write = 1'b1;
        d_pay = arg_w;
        d_plen = arg_len[3:0];
      end
    end
    if (d_nak) begin
      d_pay = {d_code, 40'h0};
    end
  end
  wire do_write = state == ST_EXEC && addr_any && d_write;

  //////////////////////////////////////////////////////////////////////
  // settings store
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      node_addr <= ADDR_DEFAULT;
      rsd_on <= 1'b1;
      spd_on <= 1'b1;
      sp_above <= 3'h0;
      sp_en <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        sp_key[i] <= SP_DEFAULT;
        hy_key[i] <= SH_DEFAULT;
      end
    end else if (do_write) begin
      if (is_ad) node_addr <= arg_w[63:40];
      if (is_rsd) rsd_on <= arg_on;
      if (is_spd) spd_on <= arg_on;
      if (is_en) sp_en[ch] <= arg_on;
      if (is_sp) begin
        sp_key[ch] <= val_key;
        hy_key[ch] <= auto_hy(val_key, sp_above[ch]);
      end
      if (is_sd) begin
        sp_above[ch] <= arg_above;
        hy_key[ch] <= auto_hy(sp_key[ch], arg_above);
      end
      if (is_sh) hy_key[ch] <= val_key;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pr_bcd <= 16'h0000;
      pr_e <= EXP_BIAS;
    end else if (meas_valid) begin
      pr_bcd <= meas_mant_bcd;
      pr_e <= meas_exp + EXP_BIAS;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // relay channels
  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic rly;
    logic [2:0] cnt;
    wire on_c = sp_above[i] ? meas_key > sp_key[i] : meas_key < sp_key[i];
    wire off_c = sp_above[i] ? meas_key < hy_key[i] : meas_key > hy_key[i];
    wire toward = rly ? off_c : on_c;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        rly <= 1'b0;
        cnt <= 3'h0;
      end else if (meas_valid) begin
        if (!sp_en[i]) begin
          rly <= 1'b0;
          cnt <= 3'h0;
        end else if (!toward) begin
          cnt <= 3'h0;
        end else if (!spd_on || cnt == SAFETY_COUNT - 3'h1) begin
          rly <= !rly;
          cnt <= 3'h0;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
    assign relay_state[i] = rly;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) relay_out <= 3'h0;
    else relay_out <= relay_state & {3{relays_fitted}};
  end

  //////////////////////////////////////////////////////////////////////
  // receive, execute, delay, transmit
  wire [4:0] tx_next = tx_idx + 5'h01;
  wire [2:0] pay_sel = 3'(tx_next - 5'd7);
  wire [4:0] tx_last = 5'd9 + {1'b0, rep_plen};
  logic [7:0] tx_char;
  always_comb begin
    tx_char = C_F;
    if (tx_next <= 5'd3) tx_char = rep_addr[23 - 8 * (tx_next - 5'd1) -: 8];
    else if (tx_next <= 5'd6) tx_char = rep_word[23 - 8 * (tx_next - 5'd4) -: 8];
    else if (tx_next < 5'd7 + {1'b0, rep_plen}) tx_char = rep_pay[63 - 8 * pay_sel -: 8];
    else if (tx_next == 5'd7 + {1'b0, rep_plen}) tx_char = C_SEMI;
  end
  wire [19:0] turn_cycles = 20'(baud_div) * 20'(TURN_BITS);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RX;
      mlen <= 5'h00;
      mactive <= 1'b0;
      rep_addr <= ADDR_DEFAULT;
      rep_word <= W_ACK;
      rep_pay <= 64'h0;
      rep_plen <= 4'h0;
      wait_cnt <= 20'h0;
      tx_idx <= 5'h00;
      tx_valid <= 1'b0;
      tx_data <= C_AT;
      baud_sel <= BAUD_SEL_DEFAULT;
    end else begin
      case (state)
        ST_RX: begin
          baud_sel <= baud_pend;
          if (rx_valid && rx_up == C_AT) begin
            mlen <= 5'h00;
            mactive <= 1'b1;
          end else if (rx_valid && mactive) begin
            if (mlen == 5'(MSG_MAX)) begin
              mactive <= 1'b0;
            end else begin
              mbuf[mlen] <= rx_up;
              mlen <= mlen + 5'h01;
              if (msg_end) begin
                mactive <= 1'b0;
                state <= ST_EXEC;
              end
            end
          end
        end
        ST_EXEC: begin
          rep_addr <= node_addr;
          rep_word <= d_nak ? W_NAK : W_ACK;
          rep_pay <= d_pay;
          rep_plen <= d_plen;
          wait_cnt <= rsd_on ? turn_cycles : 20'h0;
          state <= (addr_any && !addr_silent) ? ST_WAIT : ST_RX;
        end
        ST_WAIT: begin
          if (wait_cnt == 20'h0) begin
            state <= ST_TX;
            tx_idx <= 5'h00;
            tx_valid <= 1'b1;
            tx_data <= C_AT;
          end else begin
            wait_cnt <= wait_cnt - 20'h1;
          end
        end
        ST_TX: begin
          if (tx_ready && tx_idx == tx_last) begin
            tx_valid <= 1'b0;
            state <= ST_RX;
          end else if (tx_ready) begin
            tx_idx <= tx_next;
            tx_data <= tx_char;
          end
        end
        default: state <= ST_RX;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // avalon slave, one wait cycle per access
  wire [31:0] rd_mux = avs_address == REG_CTRL ? {25'h0, baud_pend, 1'b0, disp_unit, lock} :
                       avs_address == REG_BAUD_DIV ? {16'h0, baud_div} :
                       avs_address == REG_STATUS ? {21'h0, baud_sel, 1'b0, state != ST_RX,
                                                    spd_on, rsd_on, 1'b0, relay_state} :
                       avs_address == REG_ADDR ? {8'h0, node_addr} : 32'h0;
  wire reg_wr = avs_write && !avs_waitrequest;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      lock <= 1'b0;
      disp_unit <= 2'h0;
      baud_pend <= BAUD_SEL_DEFAULT;
      baud_div <= BAUD_DIV_DEFAULT;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= rd_mux;
      if (reg_wr && avs_address == REG_CTRL) begin
        lock <= avs_writedata[CTRL_LOCK_BIT];
        disp_unit <= avs_writedata[CTRL_UNIT_LSB +: 2];
        baud_pend <= avs_writedata[CTRL_BAUD_LSB +: BAUD_SEL_W];
      end
      if (reg_wr && avs_address == REG_BAUD_DIV) baud_div <= avs_writedata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_disabled_off;
    @(posedge core_clk) disable iff (!rst_n) !sp_en[0] && meas_valid |=> !relay_state[0];
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("disabled relay on");
  property p_lock_keeps;
    @(posedge core_clk) disable iff (!rst_n)
      state == ST_EXEC && lock |=> $stable(node_addr) && rep_word == W_NAK
        || rep_word == W_ACK && $past(is_query);
  endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("locked write applied");
  property p_silent;
    @(posedge core_clk) disable iff (!rst_n) state == ST_EXEC && addr_silent |=> state == ST_RX;
  endproperty
  a_silent: assert property (p_silent) else $error("reply on silent broadcast");
  property p_wait_quiet;
    @(posedge core_clk) disable iff (!rst_n) state == ST_WAIT |-> !tx_valid;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("tx during turnaround");
  property p_no_delay;
    @(posedge core_clk) disable iff (!rst_n)
      state == ST_EXEC && !rsd_on && addr_any && !addr_silent |=> ##1 state == ST_TX;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("delay when off");
  property p_baud_idle;
    @(posedge core_clk) disable iff (!rst_n) $changed(baud_sel) |-> $past(state) == ST_RX;
  endproperty
  a_baud_idle: assert property (p_baud_idle) else $error("baud changed mid reply");
  property p_debounce;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(relay_state[0]) && $past(spd_on) |-> $past(g_ch[0].cnt) == SAFETY_COUNT - 3'h1;
  endproperty
  a_debounce: assert property (p_debounce) else $error("trip before five");
  property p_addr_range;
    @(posedge core_clk) disable iff (!rst_n) node_addr >= ADDR_MIN && node_addr <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range");
  property p_auto_hy;
    @(posedge core_clk) disable iff (!rst_n)
      do_write && is_sp && ch == 2'h0 |=> hy_key[0] == auto_hy(sp_key[0], sp_above[0]);
  endproperty
  a_auto_hy: assert property (p_auto_hy) else $error("hysteresis not reloaded");
endmodule // ssc_top
`default_nettype wire

//--- testbench/ssc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bytes towards the device
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  // reply bytes from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  // ready only every other cycle, so the device must hold each byte
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    tx_ready <= rst_n & ~tx_ready;
  end
  // whole frames only; idle data line shows the inverse of the last byte
  task automatic send(input string s);
    foreach (s[i]) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_data <= ~s[i];
    end
  endtask
endmodule // ssc_host_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssc_pkg::*;
  typedef struct {string c; string r;} ssc_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic [2:0] baud_sel;
  logic meas_valid = 1'b0;
  logic [15:0] meas_mant_bcd = 16'h1234;
  logic [4:0] meas_exp = 5'h1d;
  logic relays_fitted = 1'b1;
  logic [2:0] relay_out;
  logic [1:0] disp_unit;
  logic [31:0] q;
  int errors = 0;
  int comparisons = 0;
  int lat;
  ssc_row_t rows[] = '{
    '{"@254RSD?;FF", "@253ACKON;FF"},
    '{"@253SPD?;FF", "@253ACKON;FF"},
    '{"@253SP1!5.00E-3;FF", "@253ACK5.00E-3;FF"},
    '{"@253SH1!6.00E-3;FF", "@253ACK6.00E-3;FF"},
    '{"@253SD1!BELOW;FF", "@253ACKBELOW;FF"},
    '{"@253SH1?;FF", "@253ACK5.50E-3;FF"},
    '{"@253SH1!6.00E-3;FF", "@253ACK6.00E-3;FF"},
    '{"@253EN1!ON;FF", "@253ACKON;FF"},
    '{"@253SPD!OFF;FF", "@253ACKOFF;FF"},
    '{"@253RSD!OFF;FF", "@253ACKOFF;FF"},
    '{"@253PR1?;FF", "@253ACK1.23E-3;FF"},
    '{"@253PR4?;FF", "@253ACK1.234E-3;FF"},
    '{"@253XY?;FF", "@253NAK160;FF"},
    '{"@253AD!000;FF", "@253NAK172;FF"},
    '{"@253AD!123;FF", "@253ACK123;FF"},
    '{"@123AD?;FF", "@123ACK123;FF"}};
  ssc_top dut_u (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready, .baud_sel, .meas_valid,
    .meas_mant_bcd, .meas_exp, .relays_fitted, .relay_out, .disp_unit);
  ssc_host_model host_u (.core_clk, .rst_n, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  always #2 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic chk_s(input string g, input string e);
    comparisons++;
    if (g != e) begin
      errors++;
      $display("Error at %0t: reply %s expected %s", $time, g, e);
    end
  endtask
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: value %h expected %h", $time, g, e);
    end
  endtask
  // leading edge keeps a release and the next request out of one time step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // empty expected reply means none may come
  task automatic cmd(input string c, input string r);
    string s;
    int n;
    host_u.got.delete();
    host_u.send(c);
    lat = 0;
    while (tx_valid !== 1'b1 && lat < 2000) begin
      @(posedge core_clk);
      lat++;
    end
    n = 0;
    while (host_u.got.size() < r.len() && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    s = "";
    foreach (host_u.got[i]) s = {s, $sformatf("%c", host_u.got[i])};
    chk_s(s, r);
  endtask
  task automatic m(input logic [15:0] b, input logic [4:0] e);
    @(posedge core_clk);
    meas_mant_bcd <= b;
    meas_exp <= e;
    meas_valid <= 1'b1;
    @(posedge core_clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100us;
    errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_v({29'h0, relay_out}, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk_v(q, 32'h00323533);
    bus(1'b0, 8'h10, 32'h0);
    chk_v(q, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk_v(q & 32'h737, 32'h130);
    bus(1'b1, 8'h04, 32'h28);
    m(16'h1234, 5'h1d);
    cmd("@253AD?;FF", "@253ACK253;FF");
    chk_v(32'(lat >= 400), 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    foreach (rows[i]) cmd(rows[i].c, rows[i].r);
    chk_v(32'(lat < 10), 32'h1);
    bus(1'b1, 8'h00, 32'h17);
    @(posedge core_clk);
    chk_v({30'h0, disp_unit}, 32'h3);
    cmd("@123SP1!2.00E-3;FF", "@123NAK180;FF");
    cmd("@123SP1?;FF", "@123ACK5.00E-3;FF");
    cmd("@123PR1?;FF", "@123ACK1.23E-3;FF");
    bus(1'b1, 8'h00, 32'h20);
    repeat (2) @(posedge core_clk);
    chk_v({29'h0, baud_sel}, 32'h2);
    m(16'h4000, 5'h1d);
    chk_v({29'h0, relay_out}, 32'h1);
    m(16'h5500, 5'h1d);
    chk_v({29'h0, relay_out}, 32'h1);
    m(16'h7000, 5'h1d);
    chk_v({29'h0, relay_out}, 32'h0);
    cmd("@255SPD!ON;FF", "");
    for (int i = 0; i < 5; i++) begin
      m(16'h4000, 5'h1d);
      chk_v({29'h0, relay_out}, 32'(i == 4));
    end
    relays_fitted <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk_v({29'h0, relay_out}, 32'h0);
    cmd("@123SP1?;FF", "@123ACK5.00E-3;FF");
    m(16'h1234, 5'h1c);
    cmd("@123PR4?;FF", "@123ACK1.200E-4;FF");
    m(16'h1234, 5'h1b);
    cmd("@123PR4?;FF", "@123ACK1.000E-5;FF");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
